// *** logic/mcc_clock_ctrl.sv ***
/*
  Main clock controller: oscillator requests, sleep gating, safe source
  switch, prescaler tick, fuse-loaded trims and the key-protected registers.
  Assumes an Avalon-MM master on core_clk; oscillator and pin levels arrive
  asynchronously and are synchronised here.
*/
// Function
// R1: oscillators off unless requested; requested oscillator starts automatically.
// R2: keep-running bit holds oscillator on except in power-down.
// R3: with keep-running set, a request is served without start-up wait.
// R4: main clock always runs in active and idle.
// R5: standby runs main clock only on request or keep-running of selected source.
// R6: power-down stops main clock once memory operations finish.
// R7: switch to external clock only after enough edges seen.
// R8: pending external switch blocks further source changes until reset.
// R9: switch-pending flag high while a source change is pending.
// R10: readable stable flags for external clock and both oscillators.
// R11: peripheral clock is main clock divided by 1 to 64.
// R12: after reset, fast oscillator selected, prescaler on, divide by 6.
// R13: fast oscillator frequency select taken from fuse at reset.
// R14: centre and slope trims loaded from fuses at reset.
// R15: trim lock fuse blocks every trim change.
// R16: trims locked when fast oscillator is main source and lock set.
// R17: oscillators ready only four own cycles after analog start-up.
// R18: software lowers main clock via prescaler before changing trims.
// R19: slow oscillator provides a 1 kHz tick to timers and detector.
// R20: external pin becomes clock input on request; usable two cycles later.
// R21: key write opens a four-access window for protected writes.
// R22: protected writes outside the window complete but change nothing.
// R23: key guards select, prescaler, lock, both oscillator controls and trims.
// R24: select codes: 0 fast, 1 slow, 3 external, 2 reserved.
// R25: division codes 0..5 give 2..64, 8..C give 6,10,12,24,48.
// R26: prescaler disabled passes main clock undivided.
// R27: lock bit freezes select, prescaler and lock until reset.
// R28: main clock stays on old source until new one is stable.
`timescale 1ns/1ns
module mcc_clock_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] sleep_mode,
  input wire logic nvm_busy,
  input wire logic main_clk_req,
  input wire logic fast_osc_req,
  input wire logic slow_osc_req,
  input wire logic ext_clk_req,
  input wire logic fast_osc_analog_ok,
  input wire logic slow_osc_analog_ok,
  input wire logic fast_osc_clk,
  input wire logic slow_osc_clk,
  input wire logic external_clock_input,
  input wire logic fuse_freq_select,
  input wire logic [5:0] fuse_center_trim,
  input wire logic [3:0] fuse_slope_trim,
  input wire logic trim_lock_fuse,
  output logic fast_osc_enable,
  output logic slow_osc_enable,
  output logic ext_pin_clock_mode,
  output logic main_clk_run,
  output logic [1:0] main_src_active,
  output logic per_clk_tick,
  output logic clk_out_enable,
  output logic fast_osc_freq_select,
  output logic [5:0] center_freq_trim,
  output logic [3:0] drift_slope_trim,
  output logic slow_khz_tick,
  output logic source_switch_pending
);

  mcc_pkg::mcc_state_t st_reg;
  mcc_pkg::mcc_state_t st_next;

  logic use_fast, use_slow, run_ok, fast_ready, slow_ready, ext_ok;
  logic tgt_ok, pend, xfer, wr_go, key_open, trim_locked;
  logic fast_flag, slow_flag, ext_flag;
  logic [4:0] idx;
  logic [7:0] wd;
  logic [6:0] ratio;

  // ****************************************
  // combinational view of the state
  // ****************************************
  always_comb begin
    idx = avs_address[6:2];
    wd = avs_writedata[7:0];
    pend = st_reg.sel != st_reg.active;
    fast_ready = st_reg.fcnt == mcc_pkg::OSC_SETTLE_CYCLES; // [R17]
    slow_ready = st_reg.scnt == mcc_pkg::OSC_SETTLE_CYCLES; // [R17]
    ext_ok = st_reg.ecnt == mcc_pkg::EXT_START_EDGES; // [R7] [R20]
    case (sleep_mode)
      mcc_pkg::SLP_ACTIVE, mcc_pkg::SLP_IDLE: main_clk_run = 1'b1; // [R4]
      mcc_pkg::SLP_STANDBY: begin
        // [R5]
        main_clk_run = main_clk_req
          | (st_reg.active == mcc_pkg::SRC_FAST & st_reg.fast_keep)
          | (st_reg.active == mcc_pkg::SRC_SLOW & st_reg.slow_keep);
      end
      default: main_clk_run = nvm_busy; // [R6]
    endcase
    run_ok = sleep_mode != mcc_pkg::SLP_POWERDOWN;
    use_fast = main_clk_run & (st_reg.active == mcc_pkg::SRC_FAST | st_reg.sel == mcc_pkg::SRC_FAST);
    use_slow = main_clk_run & (st_reg.active == mcc_pkg::SRC_SLOW | st_reg.sel == mcc_pkg::SRC_SLOW);
    fast_osc_enable = fast_osc_req | use_fast | (st_reg.fast_keep & run_ok); // [R1] [R2]
    slow_osc_enable = slow_osc_req | use_slow | (st_reg.slow_keep & run_ok); // [R1] [R2]
    ext_pin_clock_mode = ext_clk_req | st_reg.sel == mcc_pkg::SRC_EXT | st_reg.active == mcc_pkg::SRC_EXT; // [R20]
    // flags only show a source that is actually in use
    fast_flag = fast_ready & (fast_osc_req | use_fast); // [R10]
    slow_flag = slow_ready & (slow_osc_req | use_slow); // [R10]
    ext_flag = ext_ok; // [R10]
    case (st_reg.sel)
      mcc_pkg::SRC_FAST: tgt_ok = fast_ready;
      mcc_pkg::SRC_SLOW: tgt_ok = slow_ready;
      mcc_pkg::SRC_EXT: tgt_ok = ext_ok;
      default: tgt_ok = 1'b0;
    endcase
    trim_locked = trim_lock_fuse // [R15]
      | (st_reg.active == mcc_pkg::SRC_FAST & st_reg.lock); // [R16]
    ratio = mcc_pkg::mcc_div_ratio(st_reg.prescale_division); // [R25]
    xfer = (avs_read | avs_write) & st_reg.ack;
    wr_go = avs_write & st_reg.ack & avs_byteenable[0];
    key_open = st_reg.kcnt != 3'h0; // [R21]
  end

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;

    // synchronisers: first stage feeds only the second
    st_next.fa_s = {st_reg.fa_s[0], fast_osc_analog_ok};
    st_next.sa_s = {st_reg.sa_s[0], slow_osc_analog_ok};
    st_next.fc_s = {st_reg.fc_s[1:0], fast_osc_clk};
    st_next.sc_s = {st_reg.sc_s[1:0], slow_osc_clk};
    st_next.ex_s = {st_reg.ex_s[1:0], external_clock_input};

    // fuses are caught on the first edge after reset release
    if (!st_reg.loaded) begin
      st_next.loaded = 1'b1;
      st_next.freq = fuse_freq_select; // [R13]
      st_next.ctrim = fuse_center_trim; // [R14]
      st_next.strim = fuse_slope_trim; // [R14]
      st_next.lock = trim_lock_fuse;
    end

    // start-up counters count own clock edges; the oscillator ones only after analog ready, the pin one whenever in clock mode
    if (!fast_osc_enable) begin
      st_next.fcnt = 3'h0; // [R1]
    end else if (st_reg.fa_s[1] & st_reg.fc_s[1] & ~st_reg.fc_s[2] & ~fast_ready) begin
      st_next.fcnt = st_reg.fcnt + 3'h1; // [R17]
    end
    if (!slow_osc_enable) begin
      st_next.scnt = 3'h0; // [R1]
    end else if (st_reg.sa_s[1] & st_reg.sc_s[1] & ~st_reg.sc_s[2] & ~slow_ready) begin
      st_next.scnt = st_reg.scnt + 3'h1; // [R17]
    end
    if (!ext_pin_clock_mode) begin
      st_next.ecnt = 2'h0;
    end else if (st_reg.ex_s[1] & ~st_reg.ex_s[2] & ~ext_ok) begin
      st_next.ecnt = st_reg.ecnt + 2'h1; // [R7] [R20]
    end

    // 1 kHz tick from the slow oscillator
    st_next.ktick = 1'b0;
    if (slow_ready & st_reg.sc_s[1] & ~st_reg.sc_s[2]) begin
      st_next.kdiv = st_reg.kdiv + 5'h01;
      st_next.ktick = st_reg.kdiv == mcc_pkg::SLOW_KHZ_LAST; // [R19]
    end

    // source changes over only once the new source is stable
    if (pend & tgt_ok) begin
      st_next.active = st_reg.sel; // [R28] [R9]
    end

    // prescaler tick, frozen while the main clock is stopped
    if (!main_clk_run) begin
      st_next.tick = 1'b0;
    end else if (!st_reg.prescale_enable) begin
      st_next.tick = 1'b1; // [R26]
      st_next.dcnt = 6'h00;
    end else if ({1'b0, st_reg.dcnt} >= ratio - 7'h01) begin
      st_next.tick = 1'b1; // [R11]
      st_next.dcnt = 6'h00;
    end else begin
      st_next.tick = 1'b0;
      st_next.dcnt = st_reg.dcnt + 6'h01;
    end

    // bus: one wait state, read data captured in the waiting cycle
    st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
    if ((avs_read | avs_write) & ~st_reg.ack) begin
      case (idx)
        mcc_pkg::IDX_MAIN_CTRL: st_next.rdata = {st_reg.clkout, 5'h00, st_reg.sel};
        mcc_pkg::IDX_PRESCALE: st_next.rdata = {3'h0, st_reg.prescale_division, st_reg.prescale_enable};
        mcc_pkg::IDX_MAIN_LOCK: st_next.rdata = {7'h00, st_reg.lock};
        mcc_pkg::IDX_MAIN_STATUS: st_next.rdata = {ext_flag, 1'b0, slow_flag, fast_flag, 3'h0, pend}; // [R9]
        mcc_pkg::IDX_FAST_CTRL: st_next.rdata = {6'h00, st_reg.fast_keep, 1'b0};
        mcc_pkg::IDX_FAST_TRIM_A: st_next.rdata = {2'h0, st_reg.ctrim};
        mcc_pkg::IDX_FAST_TRIM_B: st_next.rdata = {trim_lock_fuse, 3'h0, st_reg.strim};
        mcc_pkg::IDX_SLOW_CTRL: st_next.rdata = {6'h00, st_reg.slow_keep, 1'b0};
        default: st_next.rdata = 8'h00;
      endcase
    end

    // key window counts completed transfers
    if (xfer) begin
      if (wr_go & idx == mcc_pkg::IDX_PROT_KEY & wd == mcc_pkg::IO_REGISTER_KEY) begin
        st_next.kcnt = mcc_pkg::KEY_WINDOW_XFERS; // [R21]
      end else if (key_open) begin
        st_next.kcnt = st_reg.kcnt - 3'h1;
      end
    end

    // protected writes: silently dropped unless the key window is open
    if (wr_go & key_open & st_reg.loaded) begin // [R22] [R23]
      case (idx)
        mcc_pkg::IDX_MAIN_CTRL: begin
          if (!st_reg.lock) begin // [R27]
            st_next.clkout = wd[mcc_pkg::CLKOUT_BIT];
            // reserved code and a pending external switch are refused
            if (wd[1:0] != mcc_pkg::SRC_RSVD & !(pend & st_reg.sel == mcc_pkg::SRC_EXT)) begin // [R8] [R24]
              st_next.sel = wd[1:0];
            end
          end
        end
        mcc_pkg::IDX_PRESCALE: begin
          if (!st_reg.lock) begin // [R27]
            st_next.prescale_division = wd[4:1];
            st_next.prescale_enable = wd[0];
          end
        end
        mcc_pkg::IDX_MAIN_LOCK: begin
          if (!st_reg.lock) begin // [R27]
            st_next.lock = wd[0];
          end
        end
        mcc_pkg::IDX_FAST_CTRL: st_next.fast_keep = wd[mcc_pkg::KEEP_RUN_BIT]; // [R2] [R3]
        mcc_pkg::IDX_SLOW_CTRL: st_next.slow_keep = wd[mcc_pkg::KEEP_RUN_BIT]; // [R2] [R3]
        mcc_pkg::IDX_FAST_TRIM_A: begin
          if (!trim_locked) begin // [R15] [R16]
            st_next.ctrim = wd[5:0];
          end
        end
        mcc_pkg::IDX_FAST_TRIM_B: begin
          if (!trim_locked) begin // [R15] [R16]
            st_next.strim = wd[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.sel <= mcc_pkg::SRC_FAST; // [R12]
      st_reg.active <= mcc_pkg::SRC_FAST; // [R12]
      st_reg.prescale_division <= mcc_pkg::PRESCALE_DIVISION_RESET; // [R12]
      st_reg.prescale_enable <= mcc_pkg::PEN_RESET; // [R12]
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
  assign avs_readdata = {24'h000000, st_reg.rdata};
  assign main_src_active = st_reg.active;
  assign per_clk_tick = st_reg.tick;
  assign clk_out_enable = st_reg.clkout & main_clk_run;
  assign fast_osc_freq_select = st_reg.freq;
  assign center_freq_trim = st_reg.ctrim;
  assign drift_slope_trim = st_reg.strim;
  assign slow_khz_tick = st_reg.ktick;
  assign source_switch_pending = pend;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence key_write_s;
    wr_go && idx == mcc_pkg::IDX_PROT_KEY && wd == mcc_pkg::IO_REGISTER_KEY;
  endsequence

  sequence closed_write_s;
    wr_go && !key_open && idx == mcc_pkg::IDX_PRESCALE;
  endsequence

  switch_wait_a: assert property (pend && !tgt_ok |=> $stable(st_reg.active)) // [R28]
    else $error("main source changed before new source stable");
  switch_done_a: assert property (pend && tgt_ok |=> st_reg.active == $past(st_reg.sel) && main_src_active == st_reg.active) // [R9]
    else $error("stable pending source not taken");
  ext_refuse_a: assert property (pend && st_reg.sel == mcc_pkg::SRC_EXT |=> st_reg.sel == mcc_pkg::SRC_EXT) // [R8]
    else $error("source select changed during external switch");
  run_active_a: assert property (sleep_mode == mcc_pkg::SLP_ACTIVE || sleep_mode == mcc_pkg::SLP_IDLE |-> main_clk_run) // [R4]
    else $error("main clock stopped in active or idle");
  pd_nvm_a: assert property (sleep_mode == mcc_pkg::SLP_POWERDOWN |-> main_clk_run == nvm_busy) // [R6]
    else $error("power-down gating wrong");
  lock_hold_a: assert property (st_reg.loaded && st_reg.lock |=> $stable({st_reg.sel, st_reg.prescale_division, st_reg.prescale_enable, st_reg.lock})) // [R27]
    else $error("locked main clock registers changed");
  trim_fuse_a: assert property (st_reg.loaded && trim_lock_fuse |=> $stable({st_reg.ctrim, st_reg.strim})) // [R15]
    else $error("trim changed under lock fuse");
  key_gate_a: assert property (closed_write_s |=> $stable({st_reg.prescale_division, st_reg.prescale_enable})) // [R22]
    else $error("protected write outside key window took effect");
  key_open_a: assert property (key_write_s |=> st_reg.kcnt == mcc_pkg::KEY_WINDOW_XFERS) // [R21]
    else $error("key write did not open window");
  undiv_a: assert property (main_clk_run && !st_reg.prescale_enable |=> per_clk_tick) // [R26]
    else $error("undivided peripheral clock missing");
  osc_off_a: assert property (!fast_osc_enable |=> !fast_ready ##1 !fast_ready) // [R1]
    else $error("fast oscillator ready while disabled");

endmodule : mcc_clock_ctrl

// *** logic/mcc_pkg.sv ***
/*
  Shared constants, types and the divider decode for the main clock
  controller. Assumes a 32-bit Avalon-MM register bus, one register per word.
*/
package mcc_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [4:0] IDX_MAIN_CTRL = 5'h00;
  localparam logic [4:0] IDX_PRESCALE = 5'h01;
  localparam logic [4:0] IDX_MAIN_LOCK = 5'h02;
  localparam logic [4:0] IDX_MAIN_STATUS = 5'h03;
  localparam logic [4:0] IDX_FAST_CTRL = 5'h10;
  localparam logic [4:0] IDX_FAST_TRIM_A = 5'h11;
  localparam logic [4:0] IDX_FAST_TRIM_B = 5'h12;
  localparam logic [4:0] IDX_SLOW_CTRL = 5'h18;
  localparam logic [4:0] IDX_PROT_KEY = 5'h1C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CLKOUT_BIT = 7;
  localparam int KEEP_RUN_BIT = 1;
  localparam int TRIM_LOCK_BIT = 7;
  localparam int STAT_EXT_BIT = 7;
  localparam int STAT_SLOW_BIT = 5;
  localparam int STAT_FAST_BIT = 4;
  localparam int STAT_PEND_BIT = 0;

  // ****************************************
  // encodings and reset values
  // ****************************************
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_RSVD = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [3:0] PRESCALE_DIVISION_RESET = 4'h8;
  localparam logic PEN_RESET = 1'b1;
  // arbitrary key value
  localparam logic [7:0] IO_REGISTER_KEY = 8'h5A;

  // ****************************************
  // timing counts
  // ****************************************
  localparam logic [2:0] KEY_WINDOW_XFERS = 3'h4;
  localparam logic [2:0] OSC_SETTLE_CYCLES = 3'h4;
  localparam logic [1:0] EXT_START_EDGES = 2'h2;
  localparam logic [4:0] SLOW_KHZ_LAST = 5'h1F;

  typedef enum logic [1:0] {
    SLP_ACTIVE,
    SLP_IDLE,
    SLP_STANDBY,
    SLP_POWERDOWN
  } mcc_sleep_t;

  typedef struct packed {
    logic loaded;
    logic [1:0] sel;
    logic clkout;
    logic [1:0] active;
    logic [3:0] prescale_division;
    logic prescale_enable;
    logic lock;
    logic fast_keep;
    logic slow_keep;
    logic [5:0] ctrim;
    logic [3:0] strim;
    logic freq;
    logic [2:0] kcnt;
    logic ack;
    logic [7:0] rdata;
    logic [1:0] fa_s;
    logic [1:0] sa_s;
    logic [2:0] fc_s;
    logic [2:0] sc_s;
    logic [2:0] ex_s;
    logic [2:0] fcnt;
    logic [2:0] scnt;
    logic [1:0] ecnt;
    logic [5:0] dcnt;
    logic tick;
    logic [4:0] kdiv;
    logic ktick;
  } mcc_state_t;

  // reserved codes fall back to the smallest ratio
  function automatic logic [6:0] mcc_div_ratio(input logic [3:0] code);
    case (code)
      4'h0: mcc_div_ratio = 7'h02;
      4'h1: mcc_div_ratio = 7'h04;
      4'h2: mcc_div_ratio = 7'h08;
      4'h3: mcc_div_ratio = 7'h10;
      4'h4: mcc_div_ratio = 7'h20;
      4'h5: mcc_div_ratio = 7'h40;
      4'h8: mcc_div_ratio = 7'h06;
      4'h9: mcc_div_ratio = 7'h0A;
      4'hA: mcc_div_ratio = 7'h0C;
      4'hB: mcc_div_ratio = 7'h18;
      4'hC: mcc_div_ratio = 7'h30;
      default: mcc_div_ratio = 7'h02;
    endcase
  endfunction : mcc_div_ratio

endpackage : mcc_pkg

// *** test/test_main_clock_source_prescaler_control.sv ***
/*
  Self-checking bench for mcc_clock_ctrl: bus tasks, request and sleep
  stimulus, oscillator and pin waveforms, one task per scenario.
  Assumes mcc_pkg and mcc_clock_ctrl are compiled before this file.
*/
`timescale 1ns/1ns
module test_main_clock_source_prescaler_control;
  logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, per_clk_tick, main_clk_run;
  logic slow_osc_analog_ok, fast_osc_clk, slow_osc_clk, external_clock_input, trim_lock_fuse;
  logic fast_osc_enable, slow_osc_enable, ext_pin_clock_mode, fast_osc_freq_select;
  logic slow_khz_tick, source_switch_pending, ext_run;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] sleep_mode, main_src_active, ph;
  logic [4:0] req;
  logic [5:0] center_freq_trim;
  logic [3:0] drift_slope_trim;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  mcc_clock_ctrl i_mcc_clock_ctrl (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
    .nvm_busy(req[4]), .main_clk_req(req[0]), .fast_osc_req(req[1]), .slow_osc_req(req[2]),
    .ext_clk_req(req[3]), .fast_osc_analog_ok(1'b1), .slow_osc_analog_ok(slow_osc_analog_ok),
    .fast_osc_clk(fast_osc_clk), .slow_osc_clk(slow_osc_clk), .external_clock_input(external_clock_input),
    .fuse_freq_select(1'b1), .fuse_center_trim(6'h2A), .fuse_slope_trim(4'h5),
    .trim_lock_fuse(trim_lock_fuse), .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
    .ext_pin_clock_mode(ext_pin_clock_mode), .main_clk_run(main_clk_run), .main_src_active(main_src_active),
    .per_clk_tick(per_clk_tick), .clk_out_enable(), .fast_osc_freq_select(fast_osc_freq_select),
    .center_freq_trim(center_freq_trim), .drift_slope_trim(drift_slope_trim),
    .slow_khz_tick(slow_khz_tick), .source_switch_pending(source_switch_pending));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // oscillator waveforms and hang guard
  // ****************************************
  // external pin stays low while stopped, so no stale edges reach the design
  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    fast_osc_clk <= ~fast_osc_clk;
    slow_osc_clk <= ph[1];
    external_clock_input <= ext_run & ph[0];
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  // values read right after the edge are the pre-edge ones, since the design updates by nba
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) n_mismatch++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // let register outputs settle before callers look at them
    @(negedge core_clk);
  endtask : bus

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic kwr(input logic [6:0] a, input logic [7:0] d);
    wr(7'h70, 8'h5A);
    wr(a, d);
  endtask : kwr

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q & m, exp);
  endtask : rd_chk

  task automatic put(input logic [1:0] m, input logic [4:0] r);
    @(posedge core_clk);
    sleep_mode <= m;
    req <= r;
    repeat (3) @(negedge core_clk);
  endtask : put

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : do_reset

  task automatic period_chk(input int exp);
    int n;
    repeat (2) begin
      n = 0;
      @(negedge core_clk);
      while (per_clk_tick !== 1'b1 && n < 200) begin
        n++;
        @(negedge core_clk);
      end
    end
    n = 1;
    @(negedge core_clk);
    while (per_clk_tick !== 1'b1 && n < 200) begin
      n++;
      @(negedge core_clk);
    end
    chk(32'(n), 32'(exp));
  endtask : period_chk

  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (main_src_active !== s && n < 400) begin
      n++;
      @(negedge core_clk);
    end
    chk(32'(main_src_active), 32'(s));
  endtask : wait_src

  function automatic int exp_div(input int c);
    int big [5] = '{6, 10, 12, 24, 48};
    return (c < 6) ? (2 << c) : big[c - 8];
  endfunction : exp_div

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(7'h04, 32'hFF, 32'h11);
    rd_chk(7'h00, 32'hFF, 32'h00);
    rd_chk(7'h08, 32'hFF, 32'h00);
    rd_chk(7'h7C, 32'hFFFFFFFF, 32'h0);
    chk(32'(main_src_active), 32'h0);
    chk(32'(fast_osc_freq_select), 32'h1);
    chk(32'({center_freq_trim, drift_slope_trim}), 32'h2A5);
    period_chk(6);
    $display("test reset done");
  endtask : t_reset

  task automatic t_protect();
    wr(7'h04, 8'h01);
    rd_chk(7'h04, 32'hFF, 32'h11);
    wr(7'h70, 8'h5A);
    repeat (4) rd_chk(7'h0C, 32'h01, 32'h00);
    wr(7'h04, 8'h01);
    rd_chk(7'h04, 32'hFF, 32'h11);
    kwr(7'h04, 8'h01);
    rd_chk(7'h04, 32'hFF, 32'h01);
    $display("test protect done");
  endtask : t_protect

  task automatic t_prescale();
    for (int c = 0; c < 13; c++) begin
      if (c == 6 || c == 7) continue;
      kwr(7'h04, {3'h0, 4'(c), 1'b1});
      period_chk(exp_div(c));
    end
    kwr(7'h04, 8'h18);
    period_chk(1);
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_gating();
    int n;
    put(2'h1, 5'h00);
    chk(32'(main_clk_run), 32'h1);
    put(2'h2, 5'h00);
    chk(32'(main_clk_run), 32'h0);
    put(2'h2, 5'h01);
    chk(32'(main_clk_run), 32'h1);
    put(2'h0, 5'h00);
    chk(32'(slow_osc_enable), 32'h0);
    kwr(7'h40, 8'h02);
    put(2'h2, 5'h00);
    chk(32'(main_clk_run), 32'h1);
    put(2'h3, 5'h10);
    chk(32'(main_clk_run), 32'h1);
    put(2'h3, 5'h00);
    chk(32'(main_clk_run), 32'h0);
    slow_osc_analog_ok <= 1'b1;
    put(2'h0, 5'h0E);
    chk(32'({slow_osc_enable, fast_osc_enable, ext_pin_clock_mode}), 32'h7);
    n = 0;
    while (slow_khz_tick !== 1'b1 && n < 600) begin
      n++;
      @(negedge core_clk);
    end
    chk(32'(slow_khz_tick), 32'h1);
    put(2'h0, 5'h00);
    kwr(7'h60, 8'h02);
    chk(32'(slow_osc_enable), 32'h1);
    put(2'h3, 5'h00);
    chk(32'(slow_osc_enable), 32'h0);
    put(2'h0, 5'h00);
    do_reset();
    $display("test gating done");
  endtask : t_gating

  task automatic t_switch();
    slow_osc_analog_ok <= 1'b0;
    kwr(7'h00, 8'h01);
    repeat (12) @(negedge core_clk);
    chk(32'({source_switch_pending, main_src_active}), 32'h4);
    rd_chk(7'h0C, 32'h01, 32'h01);
    slow_osc_analog_ok <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk(32'(main_src_active), 32'h0);
    wait_src(2'h1);
    chk(32'(source_switch_pending), 32'h0);
    put(2'h0, 5'h04);
    rd_chk(7'h0C, 32'h20, 32'h20);
    kwr(7'h00, 8'h02);
    rd_chk(7'h00, 32'h03, 32'h01);
    kwr(7'h00, 8'h03);
    repeat (30) @(negedge core_clk);
    chk(32'({source_switch_pending, main_src_active}), 32'h5);
    kwr(7'h00, 8'h00);
    rd_chk(7'h00, 32'h03, 32'h03);
    ext_run <= 1'b1;
    wait_src(2'h3);
    rd_chk(7'h0C, 32'h81, 32'h80);
    ext_run <= 1'b0;
    put(2'h0, 5'h00);
    do_reset();
    chk(32'(main_src_active), 32'h0);
    $display("test switch done");
  endtask : t_switch

  task automatic t_lock();
    kwr(7'h04, 8'h0B);
    kwr(7'h44, 8'h15);
    chk(32'(center_freq_trim), 32'h15);
    kwr(7'h04, 8'h11);
    kwr(7'h08, 8'h01);
    kwr(7'h44, 8'h33);
    chk(32'(center_freq_trim), 32'h15);
    kwr(7'h04, 8'h03);
    rd_chk(7'h04, 32'hFF, 32'h11);
    trim_lock_fuse <= 1'b1;
    do_reset();
    chk(32'(center_freq_trim), 32'h2A);
    kwr(7'h44, 8'h33);
    chk(32'(center_freq_trim), 32'h2A);
    rd_chk(7'h48, 32'h80, 32'h80);
    trim_lock_fuse <= 1'b0;
    do_reset();
    $display("test lock done");
  endtask : t_lock

  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h00;
    avs_writedata = 32'h0;
    sleep_mode = 2'h0;
    req = 5'h00;
    slow_osc_analog_ok = 1'b0;
    fast_osc_clk = 1'b0;
    slow_osc_clk = 1'b0;
    external_clock_input = 1'b0;
    trim_lock_fuse = 1'b0;
    ext_run = 1'b0;
    ph = 2'h0;
    do_reset();
    t_reset();
    t_protect();
    t_prescale();
    t_gating();
    t_switch();
    t_lock();
    give_verdict();
  end

endmodule : test_main_clock_source_prescaler_control
